// *** logic/adc_channel_digital_control.sv ***
// record channel digital control: configuration registers, digital microphone
// routing, soft-stepped coarse gain, fine gain, mute and a two-entry output buffer.
// assumes register strobes and samples are synchronous to ref_clk, and that
// sample_tick pulses once per record sample period.
// Operation
// - channel power output follows config bit 7; resets to powered down
// - source code 00 takes general io pin one, 10 takes serial data input
// - microphone bit reaches the channel only while enable bit 3 is set
// - step code 00 every sample, 01 every two, 10 and 11 immediate
// - mute bit 7 of fine register zeroes output; resets muted
// - fine code 000..100 attenuates 0 to -0.4 dB; 101..111 unused
// - coarse field is two's-complement half-dB count, -12 to +20 dB
module adc_channel_digital_control
	import adc_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// register port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// digital microphone pins and routed bit
	input wire logic general_io_pin_one,
	input wire logic serial_data_in,
	output logic dmic_bit,
	output logic dmic_active,
	// channel state
	output logic channel_power_up,
	output logic signed [6:0] applied_coarse,
	// sample rate
	input wire logic sample_tick,
	// incoming samples
	input wire logic in_valid,
	output logic in_ready,
	input wire logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] in_sample,
	// outgoing samples
	output logic out_valid,
	input wire logic out_ready,
	output logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] out_sample
);
	import adc_ctrl_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic signed [6:0] clamp_coarse(input logic [6:0] code);
		logic signed [6:0] v;
		v = $signed(code);
		if (v < COARSE_MIN) begin
			return COARSE_MIN;
		end else if (v > COARSE_MAX) begin
			return COARSE_MAX;
		end
		return v;
	endfunction

	function automatic logic [15:0] fine_coef(input logic [2:0] code);
		if (code > 3'(FINE_LAST)) begin
			return FINE_TABLE[0];
		end
		return FINE_TABLE[code];
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] mic_cfg_q, mic_cfg_d;
	logic [7:0] fine_q, fine_d;
	logic [7:0] coarse_q, coarse_d;
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		mic_cfg_d = mic_cfg_q;
		fine_d = fine_q;
		coarse_d = coarse_q;
		rdata_d = rdata_q;
		if (reg_wr_en) begin
			unique case (reg_addr)
				MIC_CFG_ADDR: mic_cfg_d = reg_wdata;
				FINE_GAIN_ADDR: fine_d = reg_wdata;
				COARSE_GAIN_ADDR: coarse_d = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd_en) begin
			unique case (reg_addr)
				MIC_CFG_ADDR: rdata_d = mic_cfg_q;
				FINE_GAIN_ADDR: rdata_d = fine_q;
				COARSE_GAIN_ADDR: rdata_d = coarse_q;
				default: rdata_d = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mic_cfg_q <= MIC_CFG_RESET;
			fine_q <= FINE_GAIN_RESET;
			coarse_q <= COARSE_GAIN_RESET;
			rdata_q <= UNMAPPED_READ;
		end else begin
			mic_cfg_q <= mic_cfg_d;
			fine_q <= fine_d;
			coarse_q <= coarse_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	logic power_on;
	logic mute_on;
	logic [1:0] step_mode;
	assign power_on = mic_cfg_q[POWER_BIT];
	assign mute_on = fine_q[MUTE_BIT];
	assign step_mode = mic_cfg_q[STEP_HI:STEP_LO];
	assign channel_power_up = power_on;

	// ****************************************
	// digital microphone routing
	// ****************************************
	logic dmic_bit_q, dmic_bit_d;
	logic dmic_active_q, dmic_active_d;

	always_comb begin
		dmic_active_d = power_on && mic_cfg_q[DMIC_EN_BIT];
		dmic_bit_d = 1'b0;
		if (dmic_active_d) begin
			unique case (mic_cfg_q[SRC_HI:SRC_LO])
				SRC_GPIO: dmic_bit_d = general_io_pin_one;
				SRC_DIN: dmic_bit_d = serial_data_in;
				default: dmic_bit_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dmic_bit_q <= 1'b0;
			dmic_active_q <= 1'b0;
		end else begin
			dmic_bit_q <= dmic_bit_d;
			dmic_active_q <= dmic_active_d;
		end
	end

	assign dmic_bit = dmic_bit_q;
	assign dmic_active = dmic_active_q;

	// ****************************************
	// coarse gain soft-stepping
	// ****************************************
	logic signed [6:0] cur_q, cur_d;
	logic half_q, half_d;
	logic signed [6:0] target;
	logic step_now;

	always_comb begin
		target = clamp_coarse(coarse_q[COARSE_HI:0]);
		half_d = half_q;
		step_now = 1'b0;
		if (sample_tick) begin
			half_d = ~half_q;
		end
		unique case (step_mode)
			STEP_EVERY: step_now = sample_tick;
			STEP_EVERY_TWO: step_now = sample_tick && half_q;
			default: step_now = 1'b0;
		endcase
		cur_d = cur_q;
		if (step_mode != STEP_EVERY && step_mode != STEP_EVERY_TWO) begin
			cur_d = target;
		end else if (step_now && cur_q < target) begin
			cur_d = cur_q + 7'sd1;
		end else if (step_now && cur_q > target) begin
			cur_d = cur_q - 7'sd1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cur_q <= 7'sd0;
			half_q <= 1'b0;
		end else begin
			cur_q <= cur_d;
			half_q <= half_d;
		end
	end

	assign applied_coarse = cur_q;

	// ****************************************
	// gain datapath
	// ****************************************
	logic [6:0] idx;
	logic [6:0] octave;
	logic [6:0] resid;
	logic signed [47:0] p_coarse, p_shift, p_fine;
	logic signed [SAMPLE_W-1:0] scaled;

	always_comb begin
		idx = 7'(cur_q) + COARSE_BIAS;
		octave = idx / STEPS_PER_OCTAVE;
		resid = idx % STEPS_PER_OCTAVE;
		// half-dB residue, then whole octaves as shifts
		p_coarse = ($signed(48'(in_sample)) * $signed({1'b0, HALF_DB_TABLE[resid[3:0]]})) >>> COARSE_FRAC;
		if (int'(octave) >= OCTAVE_BIAS) begin
			p_shift = p_coarse <<< (int'(octave) - OCTAVE_BIAS);
		end else begin
			p_shift = p_coarse >>> (OCTAVE_BIAS - int'(octave));
		end
		// fine attenuation added on top of coarse
		p_fine = (p_shift * $signed({1'b0, fine_coef(fine_q[FINE_HI:FINE_LO])})) >>> FINE_FRAC;
		if (p_fine > 48'sh7FFFFF) begin
			scaled = 24'sh7FFFFF;
		end else if (p_fine < -48'sh800000) begin
			scaled = -24'sh800000;
		end else begin
			scaled = p_fine[SAMPLE_W-1:0];
		end
		if (mute_on) begin
			scaled = '0;
		end
	end

	// ****************************************
	// two-entry output buffer
	// ****************************************
	logic signed [SAMPLE_W-1:0] mem_q [2];
	logic signed [SAMPLE_W-1:0] mem_d [2];
	logic wr_ptr_q, wr_ptr_d;
	logic rd_ptr_q, rd_ptr_d;
	logic [1:0] count_q, count_d;
	logic push, pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_sample = mem_q[rd_ptr_q];

	always_comb begin
		// powered-down channel swallows samples without output
		push = in_valid && in_ready && power_on;
		pop = out_valid && out_ready;
		mem_d = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		if (push) begin
			mem_d[wr_ptr_q] = scaled;
			wr_ptr_d = ~wr_ptr_q;
		end
		if (pop) begin
			rd_ptr_d = ~rd_ptr_q;
		end
		count_d = count_q + 2'(push) - 2'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mem_q <= '{default: '0};
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end
endmodule

// *** logic/adc_ctrl_pkg.sv ***
// constants for the record channel control block: register map, field layout,
// reset values, soft-step codes and gain tables.
// assumes 8-bit registers written by a host-side serial controller.
package adc_ctrl_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] MIC_CFG_ADDR = 8'h51;
	localparam logic [7:0] FINE_GAIN_ADDR = 8'h52;
	localparam logic [7:0] COARSE_GAIN_ADDR = 8'h53;
	localparam logic [7:0] MIC_CFG_RESET = 8'h00;
	localparam logic [7:0] FINE_GAIN_RESET = 8'h80;
	localparam logic [7:0] COARSE_GAIN_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int POWER_BIT = 7;
	localparam int SRC_HI = 5;
	localparam int SRC_LO = 4;
	localparam int DMIC_EN_BIT = 3;
	localparam int STEP_HI = 1;
	localparam int STEP_LO = 0;
	localparam int MUTE_BIT = 7;
	localparam int FINE_HI = 6;
	localparam int FINE_LO = 4;
	localparam int COARSE_HI = 6;

	// ****************************************
	// codes
	// ****************************************
	localparam logic [1:0] SRC_GPIO = 2'h0;
	localparam logic [1:0] SRC_DIN = 2'h2;
	localparam logic [1:0] STEP_EVERY = 2'h0;
	localparam logic [1:0] STEP_EVERY_TWO = 2'h1;

	// coarse gain in half-dB steps, legal span -12 dB .. +20 dB
	localparam logic signed [6:0] COARSE_MIN = -7'sd24;
	localparam logic signed [6:0] COARSE_MAX = 7'sd40;
	localparam logic [6:0] COARSE_BIAS = 7'h18;
	localparam logic [6:0] STEPS_PER_OCTAVE = 7'h0C;
	localparam int OCTAVE_BIAS = 2;

	// ****************************************
	// datapath
	// ****************************************
	localparam int SAMPLE_W = 24;
	localparam int COARSE_FRAC = 14;
	localparam int FINE_FRAC = 15;
	localparam int FINE_LAST = 4;
	// 10^(r*0.5/20) in Q14, r = 0..11
	localparam logic [15:0] HALF_DB_TABLE [12] = '{16'h4000, 16'h43CB, 16'h47CF, 16'h4C11, 16'h5092, 16'h5559,
		16'h5A67, 16'h5FC3, 16'h6570, 16'h6B72, 16'h71D0, 16'h788E};
	// 10^(-f*0.1/20) in Q15, f = 0..4
	localparam logic [15:0] FINE_TABLE [5] = '{16'h7FFF, 16'h7E89, 16'h7D16, 16'h7BA8, 16'h7A3D};
endpackage

// *** sim/adc_ctrl_chk.sv ***
// checker on the record channel control ports.
// assumes one clock and synchronous srst; bound at the foot of this file.
module adc_ctrl_chk
	import adc_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// register writes
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	// microphone and channel
	input wire logic general_io_pin_one,
	input wire logic serial_data_in,
	input wire logic dmic_bit,
	input wire logic dmic_active,
	input wire logic channel_power_up,
	input wire logic sample_tick,
	input wire logic signed [6:0] applied_coarse,
	// streams
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] out_sample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cfg_q, fine_q, crs_q;
	logic um_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// shadow registers; um_q marks an unmuted sample held since the buffer was last empty
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg_q <= MIC_CFG_RESET;
			fine_q <= FINE_GAIN_RESET;
			crs_q <= COARSE_GAIN_RESET;
			um_q <= 1'h0;
		end else begin
			if (reg_wr_en && reg_addr == MIC_CFG_ADDR) cfg_q <= reg_wdata;
			if (reg_wr_en && reg_addr == FINE_GAIN_ADDR) fine_q <= reg_wdata;
			if (reg_wr_en && reg_addr == COARSE_GAIN_ADDR) crs_q <= reg_wdata;
			um_q <= (in_valid && in_ready && !fine_q[MUTE_BIT]) || (um_q && out_valid);
		end
	end
	// ****************************************
	// properties
	// ****************************************
	power_follows_a: assert property (reg_wr_en && reg_addr == MIC_CFG_ADDR |=>
		channel_power_up == $past(reg_wdata[7])) else $error("power bit");
	mic_route_a: assert property (dmic_active && $stable(cfg_q) && !cfg_q[SRC_LO] |->
		dmic_bit == (cfg_q[SRC_HI] ? $past(serial_data_in) : $past(general_io_pin_one))) else $error("mic route");
	mic_off_a: assert property (!$past(cfg_q[DMIC_EN_BIT]) |-> !dmic_active && !dmic_bit)
		else $error("mic not off");
	gain_jump_a: assert property (cfg_q[STEP_HI:STEP_LO] == 2'h2 && $stable(cfg_q) && $stable(crs_q) |->
		applied_coarse == crs_q[6:0]) else $error("no jump");
	step_hold_a: assert property (!$past(cfg_q[STEP_HI]) && !$past(sample_tick) |-> $stable(applied_coarse))
		else $error("step off tick");
	step_one_a: assert property (!$past(cfg_q[STEP_HI]) |->
		7'(applied_coarse - $past(applied_coarse)) inside {7'h00, 7'h01, 7'h7F}) else $error("step size");
	coarse_range_a: assert property (applied_coarse >= COARSE_MIN && applied_coarse <= COARSE_MAX)
		else $error("coarse range");
	mute_zero_a: assert property (out_valid && !um_q |-> out_sample == '0)
		else $error("mute leak");
	cover property (in_valid && in_ready && channel_power_up);
	cover property (out_valid && out_ready && um_q);
	cover property (sample_tick && !cfg_q[STEP_HI] ##1 $changed(applied_coarse));
	cover property (sample_tick && cfg_q[STEP_HI:STEP_LO] == STEP_EVERY_TWO ##1 $changed(applied_coarse));
endmodule
bind adc_channel_digital_control adc_ctrl_chk i_chk(.ref_clk, .srst, .reg_wr_en, .reg_addr, .reg_wdata,
	.general_io_pin_one, .serial_data_in, .dmic_bit, .dmic_active, .channel_power_up, .sample_tick,
	.applied_coarse, .in_valid, .in_ready, .out_valid, .out_ready, .out_sample);

// *** sim/reg_host.sv ***
// host model: strobe writes and reads of the configuration registers.
// assumes callers start from a rising edge of ref_clk.
module reg_host
(
	// clock
	input wire logic ref_clk,
	// register port
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import adc_ctrl_pkg::*;
	initial begin
		reg_wr_en = 1'h0;
		reg_rd_en = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr_en <= 1'h1;
		reg_addr <= a;
		reg_wdata <= (a == FINE_GAIN_ADDR) ? {d[7:4], 4'h0} : d;
		@(posedge ref_clk);
		reg_wr_en <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd_en <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd_en <= 1'h0;
		#1 d = reg_rdata;
	endtask
endmodule

// *** sim/testbench.sv ***
// testbench: registers, mic routing, gain, soft-step and buffer.
// assumes the checker binds itself and reg_host drives the register port.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_ctrl_pkg::*;
	logic ref_clk = 1'h0, srst = 1'h1, general_io_pin_one = 1'h0, serial_data_in = 1'h0;
	logic sample_tick = 1'h0, in_valid = 1'h0, out_ready = 1'h0;
	logic reg_wr_en, reg_rd_en, dmic_bit, dmic_active, channel_power_up, in_ready, out_valid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic signed [6:0] applied_coarse;
	logic signed [23:0] in_sample = 24'h000000, out_sample, s;
	// cfg byte, pin one, data pin, expected routed bit, expected active; 0x9A selects a reserved source
	logic [11:0] mt [6] = '{12'h8AB, 12'hAA7, 12'hA2C, 12'h0A8, 12'h9AD, 12'h8A5};
	logic [7:0] cg [5] = '{8'h00, 8'h68, 8'h28, 8'h01, 8'h7F};
	int fg [5] = '{0, 4, 0, 1, 2};
	int bad_count = 0, checks_done = 0;
	real db;
	always #2 ref_clk = ~ref_clk;
	adc_channel_digital_control i_dut(.ref_clk, .srst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
		.general_io_pin_one, .serial_data_in, .dmic_bit, .dmic_active, .channel_power_up, .applied_coarse,
		.sample_tick, .in_valid, .in_ready, .in_sample, .out_valid, .out_ready, .out_sample);
	reg_host i_host(.ref_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata);
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic near(input logic signed [23:0] got, input real e);
		real t;
		t = (e < 0.0 ? -e : e) / 128.0 + 2.0;
		checks_done++;
		if ($isunknown(got) || $itor(got) > e + t || $itor(got) < e - t) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, $rtoi(e));
		end
	endtask
	task automatic push(input logic signed [23:0] v);
		in_valid <= 1'h1;
		in_sample <= v;
		@(negedge ref_clk);
		for (int k = 0; k < 50 && in_ready !== 1'h1; k++) @(negedge ref_clk);
		@(posedge ref_clk);
	endtask
	task automatic pull(input real e);
		@(negedge ref_clk);
		for (int k = 0; k < 50 && out_valid !== 1'h1; k++) @(negedge ref_clk);
		near(out_sample, e);
		@(posedge ref_clk);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			sample_tick <= 1'h1;
			@(posedge ref_clk);
			sample_tick <= 1'h0;
		end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'h0;
		i_host.rd(MIC_CFG_ADDR, rv);
		chk(rv, 8'h00);
		i_host.rd(FINE_GAIN_ADDR, rv);
		chk(rv, 8'h80);
		i_host.rd(COARSE_GAIN_ADDR, rv);
		chk(rv, 8'h00);
		i_host.rd(8'h54, rv);
		chk(rv, 8'h00);
		i_host.wr(COARSE_GAIN_ADDR, 8'h68);
		i_host.rd(COARSE_GAIN_ADDR, rv);
		chk(rv, 8'h68);
		@(posedge ref_clk);
		push(24'h001000);
		in_valid <= 1'h0;
		repeat (3) @(negedge ref_clk);
		chk(out_valid, 1'h0);
		foreach (mt[k]) begin
			i_host.wr(MIC_CFG_ADDR, mt[k][11:4]);
			general_io_pin_one <= mt[k][3];
			serial_data_in <= mt[k][2];
			repeat (3) @(negedge ref_clk);
			chk({dmic_bit, dmic_active}, mt[k][1:0]);
			chk(channel_power_up, mt[k][11]);
		end
		@(posedge ref_clk);
		out_ready <= 1'h1;
		for (int k = 0; k < 5; k++) begin
			i_host.wr(FINE_GAIN_ADDR, {1'h0, fg[k][2:0], 4'h0});
			i_host.wr(COARSE_GAIN_ADDR, cg[k]);
			db = 0.5 * $signed(cg[k][6:0]) - 0.1 * fg[k];
			s = k[0] ? -24'sh010000 : 24'sh010000;
			@(posedge ref_clk);
			push(s);
			in_valid <= 1'h0;
			pull($itor(s) * 10.0 ** (db / 20.0));
		end
		i_host.wr(FINE_GAIN_ADDR, 8'h80);
		@(posedge ref_clk);
		push(24'h010000);
		in_valid <= 1'h0;
		pull(0.0);
		i_host.wr(COARSE_GAIN_ADDR, 8'h00);
		i_host.wr(MIC_CFG_ADDR, 8'h80);
		i_host.wr(COARSE_GAIN_ADDR, 8'h04);
		repeat (5) @(negedge ref_clk);
		chk(applied_coarse, 24'h000000);
		ticks(4);
		@(negedge ref_clk);
		chk(applied_coarse, 24'h000004);
		i_host.wr(MIC_CFG_ADDR, 8'h81);
		i_host.wr(COARSE_GAIN_ADDR, 8'h00);
		ticks(4);
		@(negedge ref_clk);
		chk(applied_coarse, 24'h000002);
		@(posedge ref_clk);
		out_ready <= 1'h0;
		i_host.wr(MIC_CFG_ADDR, 8'h82);
		i_host.wr(FINE_GAIN_ADDR, 8'h00);
		@(posedge ref_clk);
		push(24'h000100);
		push(24'h000200);
		in_sample <= 24'h000300;
		repeat (3) @(negedge ref_clk);
		chk(in_ready, 1'h0);
		@(posedge ref_clk);
		in_valid <= 1'h0;
		out_ready <= 1'h1;
		pull(256.0);
		pull(512.0);
		@(negedge ref_clk);
		chk(out_valid, 1'h0);
		wrap_up;
	end
	initial begin
		repeat (4000) @(posedge ref_clk);
		bad_count++;
		wrap_up;
	end
endmodule
